//--- core/ccrk_keeper_top.sv
// Clock-run keeper: a two-stage shift register that vetoes clock stop requests.
// Assumes clkrun_b_in is the resolved line level, synchronous to the CardBus clock,
// and that the host provides the pull-up and joins the drive after a veto.
`timescale 1ns/10ps
module ccrk_keeper_top (
  input  wire logic       clk_sys_in,           // CardBus clock, 100 MHz nominal
  input  wire logic       rst_b_in,             // Asynchronous reset, active low
  input  wire logic       clk_en_in,            // Clock enable, freezes all state
  input  wire logic       clkrun_b_in,          // Clock-run line level, active low
  input  wire logic       keeper_enable_pin_in, // Enable pin from the card, high enables
  output logic            clkrun_b_out,         // Open-collector pin value (always low)
  output logic            clkrun_oe_b_out,      // Pin output enable, low while driving
  output logic            keeper_enabled_out,   // Keeper enabled after synchronising
  output logic            veto_pulse_out,       // One cycle, starting one clock after each veto starts
  output logic            stop_seen_out,        // Negation seen while disabled
  output logic [ccrk_pkg::CCRK_CNT_W-1:0] veto_count_out, // Saturating veto count
  output ccrk_pkg::ccrk_state_e           state_out       // Keeper state
);

  // Stage control bundle shared by both stages and the enable synchroniser
  ccrk_stage_if stage_ctl ();

  logic enable_s;                               // Synchronised enable pin
  logic stage1_q;                               // First stage: line sample
  logic drive_b_q;                              // Second stage: transistor off when high
  logic drive_b_d;                              // Second stage data

  // Enable and clear for both stages; a low enable clears them
  always_comb begin
    stage_ctl.ce  = clk_en_in;
    stage_ctl.clr = ~enable_s;
  end

  // Enable pin comes from outside logic: two flops; resets low, so disabled
  // A later re-enable after a wake simply restarts watching the line
  ccrk_sync u_en_sync (
    .clk_in   (clk_sys_in),
    .rst_b_in (rst_b_in),
    .ctl      (stage_ctl),
    .async_in (keeper_enable_pin_in),
    .sync_out (enable_s)
  );

  // First stage samples the line itself, closing the loop
  // Asserted line shifts in zero, so transistor stays off
  ccrk_stage #(
    .RST_VAL (ccrk_pkg::CCRK_STAGE1_RST)
  ) u_stage1 (
    .clk_in   (clk_sys_in),
    .rst_b_in (rst_b_in),
    .ctl      (stage_ctl),
    .d_in     (clkrun_b_in),
    .q_out    (stage1_q)
  );

  // Second stage stored inverted so it can feed the output enable straight
  // from a flop; a zero here means the first stage held a negated sample
  always_comb begin
    drive_b_d = ~stage1_q;
  end

  ccrk_stage #(
    .RST_VAL (ccrk_pkg::CCRK_DRIVE_B_RST)
  ) u_stage2 (
    .clk_in   (clk_sys_in),
    .rst_b_in (rst_b_in),
    .ctl      (stage_ctl),
    .d_in     (drive_b_d),
    .q_out    (drive_b_q)
  );

  // Drive ends once the asserted level reaches the second stage, two
  // clocks after it started; the host must have joined by then

  // Status group state
  logic                            drive_b_prev_r;   // Drive state one cycle ago
  logic                            drive_b_prev_nxt; // Next value
  logic                            en_r;             // Registered enable status
  logic                            en_nxt;           // Next value
  logic                            veto_pulse_r;     // Veto start pulse
  logic                            veto_pulse_nxt;   // Next value
  logic                            stop_seen_r;      // Unanswered negation flag
  logic                            stop_seen_nxt;    // Next value
  logic                            line_prev_r;      // Line level one cycle ago
  logic                            line_prev_nxt;    // Next value
  logic [ccrk_pkg::CCRK_CNT_W-1:0] cnt_r;            // Veto counter
  logic [ccrk_pkg::CCRK_CNT_W-1:0] cnt_nxt;          // Next value
  ccrk_pkg::ccrk_state_e           state_r;          // Reported state
  ccrk_pkg::ccrk_state_e           state_nxt;        // Next value
  logic                            pin_r;            // Pin data register
  logic                            pin_nxt;          // Next value
  logic                            oe_b_r;           // Mirror of the drive for the port
  logic                            oe_b_nxt;         // Next value

  // Status next values; the output enable mirrors the second stage's next value so
  // the port flop and the stage flop change on the same edge
  always_comb begin
    drive_b_prev_nxt = drive_b_prev_r;
    en_nxt           = en_r;
    veto_pulse_nxt   = veto_pulse_r;
    stop_seen_nxt    = stop_seen_r;
    line_prev_nxt    = line_prev_r;
    cnt_nxt          = cnt_r;
    state_nxt        = state_r;
    pin_nxt          = ccrk_pkg::CCRK_PIN_LOW;         // Open collector only pulls low
    oe_b_nxt         = oe_b_r;
    if (clk_en_in) begin
      drive_b_prev_nxt = drive_b_q;
      en_nxt           = enable_s;
      line_prev_nxt    = clkrun_b_in;
      // Port enable follows the stage's next value, cleared while disabled
      oe_b_nxt         = enable_s ? drive_b_d : ccrk_pkg::CCRK_DRIVE_B_RST;
      // One-cycle pulse, one clock after the transistor turns on
      veto_pulse_nxt   = drive_b_prev_r & ~drive_b_q;
      if (veto_pulse_r && (cnt_r != ccrk_pkg::CCRK_CNT_MAX)) begin
        cnt_nxt = cnt_r + 8'h01;                      // Saturate rather than wrap
      end
      // Negation while disabled goes unanswered; host may stop the clock
      // Re-enabling clears it; set needs a disabled keeper, so set and clear never fall in the same cycle
      if (!enable_s && (clkrun_b_in == ccrk_pkg::CCRK_LINE_NEGATED)
          && (line_prev_r == ccrk_pkg::CCRK_LINE_ASSERTED)) begin
        stop_seen_nxt = 1'h1;
      end else if (enable_s) begin
        stop_seen_nxt = 1'h0;
      end
      // Reported state
      case ({enable_s, drive_b_q})
        2'b10:   state_nxt = ccrk_pkg::CCRK_ST_VETO;
        2'b11:   state_nxt = ccrk_pkg::CCRK_ST_WATCH;
        default: state_nxt = ccrk_pkg::CCRK_ST_OFF;
      endcase
    end
  end

  // Status registers only
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      drive_b_prev_r <= ccrk_pkg::CCRK_DRIVE_B_RST;
      en_r           <= ccrk_pkg::CCRK_SYNC_RST;
      veto_pulse_r   <= 1'h0;
      stop_seen_r    <= 1'h0;
      line_prev_r    <= ccrk_pkg::CCRK_LINE_ASSERTED;
      cnt_r          <= ccrk_pkg::CCRK_CNT_RST;
      state_r        <= ccrk_pkg::CCRK_ST_OFF;
      pin_r          <= ccrk_pkg::CCRK_PIN_LOW;
      oe_b_r         <= ccrk_pkg::CCRK_DRIVE_B_RST;
    end else begin
      drive_b_prev_r <= drive_b_prev_nxt;
      en_r           <= en_nxt;
      veto_pulse_r   <= veto_pulse_nxt;
      stop_seen_r    <= stop_seen_nxt;
      line_prev_r    <= line_prev_nxt;
      cnt_r          <= cnt_nxt;
      state_r        <= state_nxt;
      pin_r          <= pin_nxt;
      oe_b_r         <= oe_b_nxt;
    end
  end

  // Ports straight from flops
  assign clkrun_b_out       = pin_r;
  assign clkrun_oe_b_out    = oe_b_r;           // Equal to the second stage
  assign keeper_enabled_out = en_r;
  assign veto_pulse_out     = veto_pulse_r;
  assign stop_seen_out      = stop_seen_r;
  assign veto_count_out     = cnt_r;
  assign state_out          = state_r;

endmodule : ccrk_keeper_top

//--- core/ccrk_pkg.sv
// Package for the clock-run keeper: reset values, pin levels and status widths.
// Assumes a single CardBus clock domain with an active-low asynchronous reset.
package ccrk_pkg;

  // Pin levels on the clock-run line (active low line)
  localparam logic CCRK_LINE_ASSERTED = 1'h0;  // Clock running requested
  localparam logic CCRK_LINE_NEGATED  = 1'h1;  // Clock stop requested

  // Reset values of the shift register stages (non-driving state)
  localparam logic CCRK_STAGE1_RST   = 1'h0;   // First stage holds an asserted sample
  localparam logic CCRK_DRIVE_B_RST  = 1'h1;   // Second stage: transistor off
  localparam logic CCRK_SYNC_RST     = 1'h0;   // Enable synchroniser resets disabled

  // Open-collector pin value while driving
  localparam logic CCRK_PIN_LOW      = 1'h0;   // Transistor pulls the line low

  // Saturating veto counter
  localparam int   CCRK_CNT_W        = 8;      // Width of the veto counter
  localparam logic [CCRK_CNT_W-1:0] CCRK_CNT_RST = 8'h00; // Counter reset value
  localparam logic [CCRK_CNT_W-1:0] CCRK_CNT_MAX = 8'hFF; // Counter saturation value

  // Keeper states for status reporting
  typedef enum logic [1:0] {
    CCRK_ST_OFF   = 2'b00,                     // Keeper disabled
    CCRK_ST_WATCH = 2'b01,                     // Enabled, watching the line
    CCRK_ST_VETO  = 2'b10                      // Enabled, driving the line
  } ccrk_state_e;

endpackage : ccrk_pkg

//--- core/ccrk_stage.sv
// One D-type stage of the keeper with synchronous clear and clock enable.
// Assumes clear and enable come from logic on the same clock.
`timescale 1ns/10ps
module ccrk_stage #(
  parameter logic RST_VAL = 1'h0               // Value under reset and clear
) (
  input  wire logic  clk_in,                   // CardBus clock
  input  wire logic  rst_b_in,                 // Asynchronous reset, active low
  ccrk_stage_if.stage ctl,                     // Enable and clear
  input  wire logic  d_in,                     // Serial data in
  output logic       q_out                     // Registered data out
);

  logic q_r;                                   // Stage contents
  logic q_nxt;                                 // Next stage contents

  // Clear wins over data so a disabled keeper never drives
  always_comb begin
    q_nxt = q_r;
    if (ctl.ce) begin
      q_nxt = ctl.clr ? RST_VAL : d_in;
    end
  end

  // Register only
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;

endmodule : ccrk_stage

//--- core/ccrk_stage_if.sv
// Control bundle shared by the keeper's flip-flop stages.
// Assumes every stage sits on the same clock as the driving top module.
`timescale 1ns/10ps
interface ccrk_stage_if;
  logic ce;                                    // Clock enable, freezes the stage
  logic clr;                                   // Synchronous clear to reset value

  modport ctl   (output ce, output clr);       // Driven by the top module
  modport stage (input  ce, input  clr);       // Seen by each stage
endinterface : ccrk_stage_if

//--- core/ccrk_sync.sv
// Two-flip-flop synchroniser for a level arriving from a pin.
// Assumes the level changes slowly compared with the clock.
`timescale 1ns/10ps
module ccrk_sync (
  input  wire logic  clk_in,                   // CardBus clock
  input  wire logic  rst_b_in,                 // Asynchronous reset, active low
  ccrk_stage_if.stage ctl,                     // Enable; clear is ignored here
  input  wire logic  async_in,                 // Level from the pin
  output logic       sync_out                  // Synchronised level
);

  logic meta_r;                                // First flop, read only by the second
  logic sync_r;                                // Second flop
  logic meta_nxt;                              // Next first flop
  logic sync_nxt;                              // Next second flop

  // Shift when enabled, hold otherwise
  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (ctl.ce) begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
    end
  end

  // Register only
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= ccrk_pkg::CCRK_SYNC_RST;
      sync_r <= ccrk_pkg::CCRK_SYNC_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : ccrk_sync

//--- tb/cardbus_clock_run_keeper_tb_top.sv
// Testbench for the keeper: host model, random stop requests, queued checks.
// Assumes the keeper top, its package and the host model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, ex, got); end end
module cardbus_clock_run_keeper_tb_top;
  logic                  clk_sys_in = 1'b0;   // CardBus clock
  logic                  rst_b_in   = 1'b0;   // Reset, active low
  logic                  clk_en_in  = 1'b1;   // Dropped for the freeze check
  logic                  pin        = 1'b0;   // Enable pin, pulled low
  logic                  stop_req   = 1'b0;   // Stop request to host
  logic                  wake       = 1'b0;   // Wake event to host
  logic                  slow       = 1'b0;   // Host joins late
  logic                  host_low, stopped, line, pin_d, oe_b, en, pulse, seen;
  logic [7:0]            cnt, exp_cnt, exp_v; // Count, expected, popped note
  ccrk_pkg::ccrk_state_e st;                  // Keeper state
  int                    error_cnt = 0;       // Mismatches
  int                    tests_run = 0;       // Comparisons
  logic [31:0]           lfsr = 32'hEDB0;     // Random source
  logic [7:0]            exp_q[$];            // Expected counts, oldest first
  // Wire resolution: any low drive wins, else pull-up
  assign line = (host_low || !oe_b) ? 1'b0 : 1'b1;
  initial forever #5 clk_sys_in = ~clk_sys_in;
  ccrk_keeper_top ccrk_keeper_top_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in), .clkrun_b_in(line), .keeper_enable_pin_in(pin),
    .clkrun_b_out(pin_d), .clkrun_oe_b_out(oe_b), .keeper_enabled_out(en),
    .veto_pulse_out(pulse), .stop_seen_out(seen), .veto_count_out(cnt), .state_out(st));
  ccrk_host_model ccrk_host_model_inst (.clk_in(clk_sys_in), .rst_b_in(rst_b_in),
    .stop_req_in(stop_req), .wake_in(wake), .join_slow_in(slow), .line_in(line),
    .drive_low_out(host_low), .stopped_out(stopped));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // One stop request; a veto keeps the clock running
  task automatic stop_try(input logic vetoed);
    stop_req = 1'b1;
    @(negedge clk_sys_in);
    stop_req = 1'b0;
    repeat (9) @(negedge clk_sys_in);
    `CHK("host_stopped", !vetoed, stopped)
  endtask : stop_try
  task automatic final_report();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Result watcher: each veto pulse retires the oldest note
  initial forever begin
    @(negedge clk_sys_in);
    if (pulse === 1'b1) begin
      @(negedge clk_sys_in);
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hFF;
      `CHK("veto_count", exp_v, cnt)
    end
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #50000;
    error_cnt++;
    final_report();
  end
  // Main sequence
  initial begin
    exp_cnt = 8'h00;
    repeat (16) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    @(negedge clk_sys_in);
    `CHK("rst_oe", 1'b1, oe_b)
    `CHK("rst_en", 1'b0, en)
    `CHK("rst_cnt", 8'h00, cnt)
    `CHK("rst_state", ccrk_pkg::CCRK_ST_OFF, st)
    stop_try(1'b0);
    `CHK("stop_seen", 1'b1, seen)
    $display("test disabled done");
    for (int k = 0; k < 2; k++) begin
      wake = 1'b1;
      @(negedge clk_sys_in);
      wake = 1'b0;
      pin  = 1'b1;
      repeat (6) @(negedge clk_sys_in);
      `CHK("enabled", 1'b1, en)
      `CHK("stop_clear", 1'b0, seen)
      `CHK("watch_state", ccrk_pkg::CCRK_ST_WATCH, st)
      // Frozen clock enable: a short low pulse on the pin must go unseen
      clk_en_in = 1'b0;
      pin       = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      pin = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      `CHK("frozen_en", 1'b1, en)
      `CHK("frozen_oe", 1'b1, oe_b)
      clk_en_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      for (int i = 0; i < 6; i++) begin
        lfsr = lfsr_next(lfsr);
        slow = lfsr[0];
        repeat (lfsr[3:1]) @(negedge clk_sys_in);
        exp_cnt = exp_cnt + 8'h01;
        exp_q.push_back(exp_cnt);
        stop_try(1'b1);
      end
      pin = 1'b0;
      repeat (6) @(negedge clk_sys_in);
      stop_try(1'b0);
      `CHK("stop_seen_off", 1'b1, seen)
      `CHK("off_state", ccrk_pkg::CCRK_ST_OFF, st)
      $display("test veto round %0d done", k);
    end
    `CHK("queue_empty", 0, exp_q.size())
    final_report();
  end
endmodule : cardbus_clock_run_keeper_tb_top

//--- tb/ccrk_host_model.sv
// Host controller model: holds the clock-run line low while the clock runs.
// Assumes the bench resolves the wire from its drive, the keeper and a pull-up.
`timescale 1ns/10ps
module ccrk_host_model #(
  parameter int STOP_CYC = 6          // Released cycles before the clock stops
) (
  input  wire logic clk_in,           // CardBus clock
  input  wire logic rst_b_in,         // Reset, active low
  input  wire logic stop_req_in,      // Bench asks for a clock stop
  input  wire logic wake_in,          // Wake event, restart the clock
  input  wire logic join_slow_in,     // Join the card one cycle late
  input  wire logic line_in,          // Resolved clock-run line
  output logic      drive_low_out,    // Host pulls the line low
  output logic      stopped_out       // Host has stopped the clock
);
  int   wait_r;                       // Cycles since release, 0 when idle
  logic seen_r;                       // Card assertion seen once
  // Host side of the handshake, changes only just after an edge
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      drive_low_out <= 1'b1;          // Clock running during enumeration
      stopped_out   <= 1'b0;
      wait_r        <= 0;
      seen_r        <= 1'b0;
    end else if (drive_low_out) begin
      if (stop_req_in) begin          // Driven high level equals pull-up
        drive_low_out <= 1'b0;
        wait_r        <= 1;
        seen_r        <= 1'b0;
      end
    end else if (wake_in) begin       // Wake restarts the clock
      drive_low_out <= 1'b1;
      stopped_out   <= 1'b0;
    end else if (wait_r != 0) begin
      seen_r <= !line_in;
      if (!line_in && (seen_r || !join_slow_in)) begin // Join the veto
        drive_low_out <= 1'b1;
        wait_r        <= 0;
      end else if (wait_r == STOP_CYC) begin // Unanswered, clock stops
        stopped_out <= 1'b1;
        wait_r      <= 0;
      end else begin
        wait_r <= wait_r + 1;
      end
    end
  end
endmodule : ccrk_host_model

//--- tb/ccrk_keeper_props.sv
// Checker for the keeper: veto timing and status outputs.
// Assumes it is bound to the keeper top and sees only its ports.
`timescale 1ns/10ps
module ccrk_keeper_props (
  input wire logic                          clk_sys_in,           // Clock
  input wire logic                          rst_b_in,             // Reset
  input wire logic                          clk_en_in,            // Clock enable
  input wire logic                          clkrun_b_in,          // Line
  input wire logic                          keeper_enable_pin_in, // Enable pin
  input wire logic                          clkrun_b_out,         // Pin data
  input wire logic                          clkrun_oe_b_out,      // Drive, low on
  input wire logic                          keeper_enabled_out,   // Enable seen
  input wire logic                          veto_pulse_out,       // Veto pulse
  input wire logic                          stop_seen_out,        // Stop seen
  input wire logic [ccrk_pkg::CCRK_CNT_W-1:0] veto_count_out,     // Count
  input ccrk_pkg::ccrk_state_e              state_out             // State
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // Keeper starts pulling the line
  sequence veto_start_s;
    $fell(clkrun_oe_b_out);
  endsequence
  // Held a second cycle unless disabled, then released
  sequence veto_end_s;
    (!clkrun_oe_b_out || !keeper_enabled_out) ##1 clkrun_oe_b_out;
  endsequence
  drive_follow_a: assert property (
    keeper_enabled_out && $past(keeper_enabled_out) && $past(clk_en_in) && $past(clk_en_in, 2)
    |-> clkrun_oe_b_out == !$past(clkrun_b_in, 2)) else $error("drive not from line");
  off_disabled_a: assert property (
    !keeper_enabled_out |-> clkrun_oe_b_out) else $error("drive while disabled");
  pin_low_a: assert property (
    clkrun_b_out == ccrk_pkg::CCRK_PIN_LOW) else $error("pin data not low");
  veto_length_a: assert property (
    veto_start_s |=> veto_end_s) else $error("veto drive length wrong");
  veto_pulse_a: assert property (
    veto_start_s |=> veto_pulse_out ##1 !veto_pulse_out) else $error("veto pulse wrong");
  count_step_a: assert property (
    veto_pulse_out && veto_count_out != ccrk_pkg::CCRK_CNT_MAX
    |=> veto_count_out == $past(veto_count_out) + 8'h01) else $error("count no step");
  count_hold_a: assert property (
    !veto_pulse_out |=> $stable(veto_count_out)) else $error("count moved");
  enable_on_a: assert property (
    $rose(keeper_enable_pin_in) ##1 keeper_enable_pin_in [*4] |-> keeper_enabled_out)
    else $error("enable not seen");
  enable_off_a: assert property (
    $fell(keeper_enable_pin_in) ##1 !keeper_enable_pin_in [*4]
    |-> !keeper_enabled_out && clkrun_oe_b_out) else $error("disable not seen");
  state_veto_a: assert property (
    !$past(clkrun_oe_b_out) && keeper_enabled_out && $past(clk_en_in)
    |-> state_out == ccrk_pkg::CCRK_ST_VETO) else $error("state wrong");
endmodule : ccrk_keeper_props

bind ccrk_keeper_top ccrk_keeper_props ccrk_keeper_props_inst (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
  .clkrun_b_in(clkrun_b_in), .keeper_enable_pin_in(keeper_enable_pin_in),
  .clkrun_b_out(clkrun_b_out), .clkrun_oe_b_out(clkrun_oe_b_out),
  .keeper_enabled_out(keeper_enabled_out), .veto_pulse_out(veto_pulse_out),
  .stop_seen_out(stop_seen_out), .veto_count_out(veto_count_out), .state_out(state_out));
